// >>> rtl/gcsg_pkg.sv
// Package with the constants and carrier types of the global clock select and gate block.
package gcsg_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int         SEL_W        = 2;
	localparam int         PLL_OUTS     = 5;
	localparam int         ADJ_OUTS     = 4;
	localparam int         PICK_W       = 2;
	localparam int         REF_INPUTS   = 2;

	// ----------------------------------------------------------------
	// Source select encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] SRC_PIN0     = 2'h0;
	localparam logic [1:0] SRC_PIN1     = 2'h1;
	localparam logic [1:0] SRC_PLL_A    = 2'h2;
	localparam logic [1:0] SRC_PLL_B    = 2'h3;
	localparam logic [1:0] SEL_RESET    = 2'h0;
	localparam logic       ENA_RESET    = 1'b0;

	// ----------------------------------------------------------------
	// Divider for the modelled PLL post-scaler outputs
	// ----------------------------------------------------------------
	localparam int         DIV_W        = 4;
	localparam logic [3:0] DIV_RESET    = 4'h0;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] src_sel;
		logic       enable;
	} gcsg_ctrl_t;

	typedef struct packed {
		logic [1:0] pick_a;
		logic [1:0] pick_b;
		logic       ref_sel;
		logic       diff_mode;
		logic       ext_used;
		logic       dyn_ref;
	} gcsg_cfg_t;

	typedef struct packed {
		logic       pos_out;
		logic       pos_oe;
		logic       neg_out;
		logic       neg_oe;
	} gcsg_pins_t;

endpackage

// >>> rtl/gcsg_top.sv
// Global clock select, gate and external clock output logic as one module.
//
// How it works
// - Reference mux output feeds PLL input.
// - Core two-bit select picks global source.
// - Static settings frozen during user mode.
// - Two of four adjacent PLL outputs taken.
// - Core enable gates the global network.
// - Each PLL provides five post-scaled outputs.
// - At most two outputs reach global network.
// - Differential pins driven in complement.
// - Pin pair differential or single-ended.
// - Global network clock reaches any I/O.
// - Unused clock pins act as GPIO.
module gcsg_top #(
	parameter int DIV_W = gcsg_pkg::DIV_W
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Configuration and user mode
	input  wire logic                      user_mode,
	input  wire gcsg_pkg::gcsg_cfg_t       cfg_in,
	// Core controls
	input  wire gcsg_pkg::gcsg_ctrl_t      ctrl_in,
	input  wire logic                      manual_switch,
	input  wire logic [DIV_W-1:0]          div_ratio,
	// Clock candidates, sampled as levels
	input  wire logic [1:0]                pin_clk,
	input  wire logic [3:0]                adj_pll_out,
	// Reference to PLL and post-scaler view
	output logic                           pll_ref_clk,
	output logic [4:0]                     pll_post_out,
	// Global network and regular I/O tap
	output logic                           global_clock_net,
	output logic                           io_clock_tap,
	// External output pair and GPIO
	input  wire logic                      gpio_pos_out,
	input  wire logic                      gpio_pos_oe,
	input  wire logic                      gpio_neg_out,
	input  wire logic                      gpio_neg_oe,
	output gcsg_pkg::gcsg_pins_t           pins
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]       rst_sync;
		logic [2:0][1:0]  pin_sync;
		logic [2:0][3:0]  pll_sync;
		logic [1:0]       pin_held;
		logic [3:0]       pll_held;
		gcsg_pkg::gcsg_cfg_t cfg;
		logic [1:0]       sel_live;
		logic             ena_live;
		logic             ref_live;
		logic [DIV_W-1:0] div_cnt;
		logic [4:0]       post;
		logic             ref_clk;
		logic             gnet;
		logic             io_tap;
		gcsg_pkg::gcsg_pins_t pins;
	} gcsg_state_t;

	gcsg_state_t st;
	gcsg_state_t next_st;

	logic [1:0] pin_now;
	logic [3:0] pll_now;
	logic [1:0] cand_a;
	logic       cand;
	logic       low_phase;

	// A lone disagreeing sample keeps the old level, so a slow pin edge cannot flicker through.
	function automatic logic settle(input logic b2, input logic b3, input logic held);
		settle = (b2 == b3) ? b3 : held;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.rst_sync = {st.rst_sync[0], 1'b1};
		next_st.pin_sync = {st.pin_sync[1:0], pin_clk};
		next_st.pll_sync = {st.pll_sync[1:0], adj_pll_out};
		// A level counts once the second and third stages agree.
		for (int i = 0; i < 2; i++) begin
			pin_now[i] = settle(st.pin_sync[1][i], st.pin_sync[2][i], st.pin_held[i]);
		end
		for (int j = 0; j < 4; j++) begin
			pll_now[j] = settle(st.pll_sync[1][j], st.pll_sync[2][j], st.pll_held[j]);
		end
		next_st.pin_held = pin_now;
		next_st.pll_held = pll_now;
		if (!user_mode) begin
			next_st.cfg = cfg_in;
		end
		// Dynamic reference switch under manual switchover, else static.
		next_st.ref_live = st.cfg.dyn_ref ? manual_switch : st.cfg.ref_sel;
		next_st.ref_clk = pin_now[st.ref_live];
		// Post-scalers modelled as a divided copy of clk, independent of the reference.
		next_st.div_cnt = st.div_cnt + 1'b1;
		if (st.div_cnt >= div_ratio) begin
			next_st.div_cnt = DIV_W'(gcsg_pkg::DIV_RESET);
			next_st.post = ~st.post;
		end
		cand_a[0] = pll_now[st.cfg.pick_a];
		cand_a[1] = pll_now[st.cfg.pick_b];
		// Controls load only while the network is low, so no pulse is cut.
		low_phase = ~st.gnet;
		if (low_phase && user_mode) begin
			next_st.sel_live = ctrl_in.src_sel;
			next_st.ena_live = ctrl_in.enable;
		end
		unique case (st.sel_live)
			gcsg_pkg::SRC_PIN0:  cand = pin_now[0];
			gcsg_pkg::SRC_PIN1:  cand = pin_now[1];
			gcsg_pkg::SRC_PLL_A: cand = cand_a[0];
			gcsg_pkg::SRC_PLL_B: cand = cand_a[1];
		endcase
		next_st.gnet = cand & st.ena_live & user_mode;
		next_st.io_tap = st.gnet;
		if (st.cfg.ext_used) begin
			next_st.pins.pos_out = st.gnet;
			next_st.pins.pos_oe = 1'b1;
			if (st.cfg.diff_mode) begin
				next_st.pins.neg_out = ~st.gnet;
				next_st.pins.neg_oe = 1'b1;
			end else begin
				next_st.pins.neg_out = gpio_neg_out;
				next_st.pins.neg_oe = gpio_neg_oe;
			end
		end else begin
			next_st.pins = '{gpio_pos_out, gpio_pos_oe, gpio_neg_out, gpio_neg_oe};
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else if (!st.rst_sync[1]) begin
			st <= '0;
			st.rst_sync <= next_st.rst_sync;
		end else begin
			st <= next_st;
		end
	end

	assign pll_ref_clk = st.ref_clk;
	assign pll_post_out = st.post;
	assign global_clock_net = st.gnet;
	assign io_clock_tap = st.io_tap;
	assign pins = st.pins;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_net_high;
		global_clock_net;
	endsequence

	a_gate_off_low: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		!st.ena_live |=> !global_clock_net) else $error("net high while gated");
	a_sel_hold_high: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		s_net_high |=> $stable(st.sel_live) && $stable(st.ena_live)) else $error("control changed in high phase");
	a_diff_compl: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		st.cfg.ext_used && st.cfg.diff_mode |=> pins.neg_oe && pins.neg_out == ~pins.pos_out)
		else $error("pair not complementary");
	a_static_frozen: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		user_mode && $past(user_mode) |-> $stable(st.cfg)) else $error("static setting changed");
	a_gpio_pass: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		!st.cfg.ext_used |=> pins.pos_oe == $past(gpio_pos_oe)) else $error("gpio not passed");
	a_single_gpio: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		st.cfg.ext_used && !st.cfg.diff_mode |=> pins.neg_oe == $past(gpio_neg_oe)) else $error("second pin not gpio");
	a_io_follows: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		##1 io_clock_tap == $past(global_clock_net)) else $error("io tap lags wrong");
	a_not_user_off: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		!user_mode |=> !global_clock_net) else $error("net active outside user mode");

	// ----------------------------------------------------------------
	// Checks on the reference and the post-scalers
	// ----------------------------------------------------------------
	sequence s_div_wrap;
		st.div_cnt >= div_ratio;
	endsequence

	a_ref_static: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		!st.cfg.dyn_ref |=> st.ref_live == $past(st.cfg.ref_sel))
		else $error("static reference select ignored");
	a_ref_manual: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		st.cfg.dyn_ref |=> st.ref_live == $past(manual_switch))
		else $error("manual switchover ignored");
	a_ref_out: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		##1 pll_ref_clk == $past(pin_now[st.ref_live]))
		else $error("reference does not follow its input");
	a_post_toggle: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		s_div_wrap |=> pll_post_out == ~$past(pll_post_out))
		else $error("post-scaler missed its toggle");
	a_post_hold: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		st.div_cnt < div_ratio |=> $stable(pll_post_out))
		else $error("post-scaler toggled early");

	// ----------------------------------------------------------------
	// Checks on select, gate and pin drive
	// ----------------------------------------------------------------
	sequence s_user_low;
		!global_clock_net && user_mode;
	endsequence

	sequence s_pll_a_live;
		st.sel_live == gcsg_pkg::SRC_PLL_A && st.ena_live && user_mode;
	endsequence

	sequence s_pll_b_live;
		st.sel_live == gcsg_pkg::SRC_PLL_B && st.ena_live && user_mode;
	endsequence

	a_ena_load: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		s_user_low |=> st.ena_live == $past(ctrl_in.enable))
		else $error("enable not taken in low phase");
	a_sel_load: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		s_user_low |=> st.sel_live == $past(ctrl_in.src_sel))
		else $error("select not taken in low phase");
	a_pick_first: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		s_pll_a_live |=> global_clock_net == $past(pll_now[st.cfg.pick_a]))
		else $error("first picked output not routed");
	a_pick_second: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		s_pll_b_live |=> global_clock_net == $past(pll_now[st.cfg.pick_b]))
		else $error("second picked output not routed");
	a_ext_drive: assert property (@(posedge clk) disable iff (!st.rst_sync[1])
		st.cfg.ext_used |=> pins.pos_oe && pins.pos_out == $past(global_clock_net))
		else $error("clock pin not driven from the network");

endmodule

// >>> verif/gcsg_core_model.sv
// Core logic model that drives the source select and gate enable.
module gcsg_core_model (
	// Clock
	input  wire logic           clk,
	// Requests from the bench
	input  wire logic [1:0]     want_src,
	input  wire logic           want_ena,
	// Controls into the block
	output gcsg_pkg::gcsg_ctrl_t ctrl = '0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered, so controls move just after an edge as real core logic does.
	always @(posedge clk) begin
		ctrl.src_sel <= want_src;
		ctrl.enable  <= want_ena;
	end
endmodule

// >>> verif/gcsg_top_tb_top.sv
// Self-checking bench for the global clock select and gate block.
module gcsg_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk       = 1'b0;
	logic                 rst_n     = 1'b0;
	logic                 user_mode = 1'b0;
	gcsg_pkg::gcsg_cfg_t  cfg       = '0;
	logic [1:0]           want_src  = 2'h0;
	logic                 want_ena  = 1'b0;
	logic [1:0]           pin_clk   = 2'h0;
	logic [3:0]           adj       = 4'h0;
	logic [3:0]           gpio      = 4'h0;
	logic                 manual    = 1'b0;
	gcsg_pkg::gcsg_ctrl_t ctrl;
	gcsg_pkg::gcsg_pins_t pins;
	logic                 ref_clk;
	logic                 net;
	logic                 tap;
	logic [4:0]           post;
	int                   bad_count   = 0;
	int                   comparisons = 0;
	always #4 clk = ~clk;
	gcsg_core_model gcsg_core_model_i (.clk(clk), .want_src(want_src), .want_ena(want_ena), .ctrl(ctrl));
	gcsg_top gcsg_top_i (.clk(clk), .rst_n(rst_n), .user_mode(user_mode), .cfg_in(cfg), .ctrl_in(ctrl),
		.manual_switch(manual), .div_ratio(4'h1), .pin_clk(pin_clk), .adj_pll_out(adj),
		.pll_ref_clk(ref_clk), .pll_post_out(post), .global_clock_net(net), .io_clock_tap(tap),
		.gpio_pos_out(gpio[3]), .gpio_pos_oe(gpio[2]), .gpio_neg_out(gpio[1]), .gpio_neg_oe(gpio[0]),
		.pins(pins));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask
	task automatic close_out;
		$display("mismatches %0d, comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic test_sources;
		int idx[4] = '{0, 1, 3, 5};
		for (int s = 0; s < 4; s++) begin
			{adj, pin_clk} <= 6'h0;
			want_ena <= 1'b1;
			want_src <= 2'(s);
			step(8);
			{adj, pin_clk} <= 6'h1 << idx[s];
			step(8);
			chk("net from chosen source", 1'b1, net);
			chk("io tap", 1'b1, tap);
			{adj, pin_clk} <= ~(6'h1 << idx[s]);
			step(8);
			chk("net with other sources high", 1'b0, net);
		end
	endtask
	task automatic test_pins;
		logic p;
		adj <= 4'h8;
		step(8);
		chk("pos pin follows net", 1'b1, pins.pos_out);
		chk("neg pin in complement", 1'b0, pins.neg_out);
		for (int i = 0; i < 4; i++) begin
			adj[3] <= ~adj[3];
			p = post[0];
			step(2);
			chk("post-scaler toggle", ~p, post[0]);
			chk("complement pin", ~pins.pos_out, pins.neg_out);
			chk("neg pin driven", 1'b1, pins.neg_oe);
		end
	endtask
	task automatic test_ref;
		cfg.ref_sel <= 1'b0;
		pin_clk <= 2'h2;
		step(8);
		chk("reference kept in user mode", 1'b1, ref_clk);
		pin_clk <= 2'h1;
		step(8);
		chk("reference follows pin", 1'b0, ref_clk);
	endtask
	task automatic test_gate;
		adj      <= 4'h0;
		pin_clk  <= 2'h0;
		want_src <= gcsg_pkg::SRC_PIN0;
		step(8);
		want_ena <= 1'b0;
		step(4);
		pin_clk <= 2'h1;
		step(8);
		chk("gated net", 1'b0, net);
		want_ena <= 1'b1;
		step(8);
		chk("re-enabled net", 1'b1, net);
		chk("io tap after enable", 1'b1, tap);
		want_ena <= 1'b0;
		step(8);
		chk("enable held while net high", 1'b1, net);
		pin_clk <= 2'h0;
		step(8);
		pin_clk <= 2'h1;
		step(8);
		chk("enable taken at low phase", 1'b0, net);
	endtask
	task automatic test_gpio;
		user_mode <= 1'b0;
		cfg.ext_used <= 1'b0;
		cfg.diff_mode <= 1'b0;
		gpio <= 4'hb;
		step(8);
		for (int b = 0; b < 4; b++) begin
			chk("pad drive", gpio[b], pins[b]);
		end
	endtask
	task automatic test_dyn_ref;
		cfg.dyn_ref  <= 1'b1;
		cfg.ext_used <= 1'b1;
		gpio         <= 4'h1;
		pin_clk      <= 2'h1;
		manual       <= 1'b0;
		step(8);
		chk("reference under manual switch low", 1'b1, ref_clk);
		chk("single-ended neg pin", 1'b0, pins.neg_out);
		chk("single-ended neg enable", 1'b1, pins.neg_oe);
		chk("single-ended pos enable", 1'b1, pins.pos_oe);
		chk("net outside user mode", 1'b0, net);
		manual <= 1'b1;
		step(8);
		chk("reference under manual switch high", 1'b0, ref_clk);
	endtask
	// Watchdog: the scenarios need well under 500 cycles.
	initial begin
		#20000;
		bad_count++;
		close_out;
	end
	initial begin
		step(12);
		chk("net in reset", 1'b0, net);
		rst_n <= 1'b1;
		cfg <= '{pick_a: 2'h1, pick_b: 2'h3, ref_sel: 1'b1, diff_mode: 1'b1, ext_used: 1'b1, dyn_ref: 1'b0};
		step(6);
		user_mode <= 1'b1;
		test_sources();
		test_pins();
		test_ref();
		test_gate();
		test_gpio();
		test_dyn_ref();
		close_out();
	end
endmodule
